//--- logic/uio_consts.vh
`ifndef UIO_CONSTS_VH
`define UIO_CONSTS_VH
// ****************************************
// register offsets
// ****************************************
`define UIO_OFS_DIR      8'h00
`define UIO_OFS_PULL_EN  8'h04
`define UIO_OFS_PULL_UP  8'h08
`define UIO_OFS_OUT_INIT 8'h0C
`define UIO_OFS_ANA      8'h10
`define UIO_OFS_LED      8'h14
`define UIO_OFS_SDIR     8'h18
`define UIO_OFS_SPULL_EN 8'h1C
`define UIO_OFS_SPULL_UP 8'h20
`define UIO_OFS_SOUT     8'h24
`define UIO_OFS_DATA     8'h28
`define UIO_OFS_DEBUG    8'h2C
`define UIO_OFS_CTRL     8'h30
`define UIO_OFS_CNT_TX   8'h34
`define UIO_OFS_CNT_ACKS 8'h38
`define UIO_OFS_CNT_RX   8'h3C
`define UIO_OFS_CNT_ACKR 8'h40
// ****************************************
// field positions
// ****************************************
`define UIO_LED_ONB_G    0
`define UIO_LED_ONB_R    1
`define UIO_LED_BRD_R    2
`define UIO_LED_BRD_Y    3
`define UIO_LED_RF_EN    4
`define UIO_LED_SER_EN   5
`define UIO_LED_HB_EN    6
`define UIO_CTRL_CLR     0
`define UIO_CTRL_RPT_GO  1
`define UIO_CTRL_RPT_STP 2
`define UIO_CTRL_APPLY   3
`define UIO_PIN_NOPULL_A 8
`define UIO_PIN_NOPULL_B 9
// ****************************************
// reset values
// ****************************************
`define UIO_RST_DIR      12'h000
`define UIO_RST_PULL_EN  12'h000
`define UIO_RST_PULL_UP  2'h3
`define UIO_RST_OUT      12'h000
`define UIO_RST_ANA      8'h00
`define UIO_RST_LED      7'h00
`define UIO_RST_DEBUG    2'h0
// ****************************************
// timing
// ****************************************
`define UIO_CLK_KHZ      40000
`define UIO_HB_MS        2000
`define UIO_RPT_MS       100
`define UIO_FLASH_MS     20
`define UIO_HB_CYC       (`UIO_HB_MS * `UIO_CLK_KHZ)
`define UIO_RPT_CYC      (`UIO_RPT_MS * `UIO_CLK_KHZ)
`define UIO_FLASH_CYC    (`UIO_FLASH_MS * `UIO_CLK_KHZ)
`endif

//--- logic/uio_top.v
`include "uio_consts.vh"

module uio_top #(
    parameter HB_CYC    = `UIO_HB_CYC,
    parameter RPT_CYC   = `UIO_RPT_CYC,
    parameter FLASH_CYC = `UIO_FLASH_CYC
) (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    input  wire [11:0] pin_in,
    output reg  [11:0] pin_out,
    output reg  [11:0] pin_oe,
    output reg  [11:0] pin_pu,
    output reg  [11:0] pin_pd,
    output reg  [7:0]  pin_ana,
    input  wire        sleep,
    input  wire        rf_tx_evt,
    input  wire        rf_rx_evt,
    input  wire        ser_tx_evt,
    input  wire        ser_rx_evt,
    input  wire        ack_tx_evt,
    input  wire        ack_rx_evt,
    output reg         dbg_pulse,
    output reg         rpt_send,
    output reg         rpt_active
);

    // ****************************************
    // decode
    // ****************************************
    function [4:0] reg_idx;
        input [7:0] a;
        begin
            reg_idx = (a[7] | a[1] | a[0]) ? 5'h1F : a[6:2];
        end
    endfunction

    function [11:0] pull_ok;
        input [11:0] v;
        begin
            pull_ok = v;
            pull_ok[`UIO_PIN_NOPULL_A] = 1'b0;
            pull_ok[`UIO_PIN_NOPULL_B] = 1'b0;
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    reg  [11:0] dir_q;
    reg  [11:0] pen_q;
    reg  [1:0]  pup_q;
    reg  [11:0] oinit_q;
    reg  [7:0]  ana_q;
    reg  [6:0]  led_q;
    reg  [11:0] sdir_q;
    reg  [11:0] spen_q;
    reg  [1:0]  spup_q;
    reg  [11:0] sout_q;
    reg  [11:0] out_q;
    reg  [1:0]  dbg_q;
    reg  [15:0] cnt_q [0:3];
    reg  [11:0] sync1_q;
    reg  [11:0] sync2_q;
    reg         wr_pend_q;
    reg         rd_pend_q;
    reg  [7:0]  addr_q;
    reg  [31:0] hb_q;
    reg  [31:0] rpt_q;
    reg         clr_q;
    wire        acc;
    wire        hb_tick;
    wire [3:0]  flash_evt;
    wire [3:0]  flash_on;
    wire [3:0]  cnt_evt;
    wire [11:0] pen_eff;
    wire [11:0] spen_eff;
    reg  [31:0] rd_d;

    assign acc = hsel & hready & htrans[1];

    // ****************************************
    // ahb-lite slave
    // ****************************************
    always @(posedge clock) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
        end else begin
            hresp     <= 1'b0;
            wr_pend_q <= acc & hwrite;
            rd_pend_q <= acc & ~hwrite;
            if (acc) begin
                addr_q <= haddr[7:0];
            end
            hreadyout <= ~(acc & ~hwrite);
            if (rd_pend_q) begin
                hrdata <= rd_d;
            end
        end
    end

    always @* begin
        rd_d = 32'h00000000;
        case (addr_q)
            `UIO_OFS_DIR:      rd_d[11:0] = dir_q;
            `UIO_OFS_PULL_EN:  rd_d[11:0] = pen_q;
            `UIO_OFS_PULL_UP:  rd_d[1:0]  = pup_q;
            `UIO_OFS_OUT_INIT: rd_d[11:0] = oinit_q;
            `UIO_OFS_ANA:      rd_d[7:0]  = ana_q;
            `UIO_OFS_LED:      rd_d[6:0]  = led_q;
            `UIO_OFS_SDIR:     rd_d[11:0] = sdir_q;
            `UIO_OFS_SPULL_EN: rd_d[11:0] = spen_q;
            `UIO_OFS_SPULL_UP: rd_d[1:0]  = spup_q;
            `UIO_OFS_SOUT:     rd_d[11:0] = sout_q;
            `UIO_OFS_DATA:     rd_d[11:0] = sync2_q & ~dir_q & ~{4'h0, ana_q};
            `UIO_OFS_DEBUG:    rd_d[1:0]  = dbg_q;
            `UIO_OFS_CTRL:     rd_d[`UIO_CTRL_RPT_GO] = rpt_active;
            `UIO_OFS_CNT_TX:   rd_d[15:0] = cnt_q[0];
            `UIO_OFS_CNT_ACKS: rd_d[15:0] = cnt_q[1];
            `UIO_OFS_CNT_RX:   rd_d[15:0] = cnt_q[2];
            `UIO_OFS_CNT_ACKR: rd_d[15:0] = cnt_q[3];
            default:           rd_d = 32'h00000000;
        endcase
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always @(posedge clock) begin
        if (!rst_n) begin
            dir_q   <= `UIO_RST_DIR;
            pen_q   <= `UIO_RST_PULL_EN;
            pup_q   <= `UIO_RST_PULL_UP;
            oinit_q <= `UIO_RST_OUT;
            ana_q   <= `UIO_RST_ANA;
            led_q   <= `UIO_RST_LED;
            sdir_q  <= `UIO_RST_DIR;
            spen_q  <= `UIO_RST_PULL_EN;
            spup_q  <= `UIO_RST_PULL_UP;
            sout_q  <= `UIO_RST_OUT;
            out_q   <= `UIO_RST_OUT;
            dbg_q   <= `UIO_RST_DEBUG;
            clr_q   <= 1'b0;
        end else begin
            clr_q <= 1'b0;
            if (wr_pend_q) begin
                case (reg_idx(addr_q))
                    reg_idx(`UIO_OFS_DIR):      dir_q   <= hwdata[11:0];
                    reg_idx(`UIO_OFS_PULL_EN):  pen_q   <= pull_ok(hwdata[11:0]);
                    reg_idx(`UIO_OFS_PULL_UP):  pup_q   <= hwdata[1:0];
                    reg_idx(`UIO_OFS_OUT_INIT): oinit_q <= hwdata[11:0];
                    reg_idx(`UIO_OFS_ANA):      ana_q   <= hwdata[7:0];
                    reg_idx(`UIO_OFS_LED): begin
                        led_q <= hwdata[6:0];
                        if (|hwdata[`UIO_LED_ONB_R:`UIO_LED_ONB_G]) begin
                            led_q[`UIO_LED_BRD_Y:`UIO_LED_BRD_R] <= 2'h0;
                        end else if (|hwdata[`UIO_LED_BRD_Y:`UIO_LED_BRD_R]) begin
                            led_q[`UIO_LED_ONB_R:`UIO_LED_ONB_G] <= 2'h0;
                        end
                    end
                    reg_idx(`UIO_OFS_SDIR):     sdir_q <= hwdata[11:0];
                    reg_idx(`UIO_OFS_SPULL_EN): spen_q <= pull_ok(hwdata[11:0]);
                    reg_idx(`UIO_OFS_SPULL_UP): spup_q <= hwdata[1:0];
                    reg_idx(`UIO_OFS_SOUT):     sout_q <= hwdata[11:0];
                    reg_idx(`UIO_OFS_DATA):     out_q  <= hwdata[11:0];
                    reg_idx(`UIO_OFS_DEBUG):    dbg_q  <= hwdata[1:0];
                    reg_idx(`UIO_OFS_CTRL): begin
                        clr_q <= hwdata[`UIO_CTRL_CLR];
                        if (hwdata[`UIO_CTRL_APPLY]) begin
                            out_q <= oinit_q;
                        end
                    end
                    default: clr_q <= 1'b0;
                endcase
            end
        end
    end

    // ****************************************
    // input synchroniser
    // ****************************************
    always @(posedge clock) begin
        if (!rst_n) begin
            sync1_q <= 12'h000;
            sync2_q <= 12'h000;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // ****************************************
    // heartbeat and repeat timers
    // ****************************************
    assign hb_tick = (hb_q == HB_CYC - 1);

    always @(posedge clock) begin
        if (!rst_n) begin
            hb_q       <= 32'h00000000;
            rpt_q      <= 32'h00000000;
            rpt_active <= 1'b0;
            rpt_send   <= 1'b0;
        end else begin
            hb_q     <= hb_tick ? 32'h00000000 : hb_q + 32'h00000001;
            rpt_send <= 1'b0;
            if (wr_pend_q && reg_idx(addr_q) == reg_idx(`UIO_OFS_CTRL) && hwdata[`UIO_CTRL_RPT_STP]) begin
                rpt_active <= 1'b0;
            end else if (wr_pend_q && reg_idx(addr_q) == reg_idx(`UIO_OFS_CTRL) && hwdata[`UIO_CTRL_RPT_GO]) begin
                rpt_active <= 1'b1;
                rpt_q      <= 32'h00000000;
                rpt_send   <= 1'b1;
            end else if (rpt_active) begin
                if (rpt_q == RPT_CYC - 1) begin
                    rpt_q    <= 32'h00000000;
                    rpt_send <= 1'b1;
                end else begin
                    rpt_q <= rpt_q + 32'h00000001;
                end
            end
        end
    end

    // ****************************************
    // indicator flashes
    // ****************************************
    wire rx_any = (led_q[`UIO_LED_RF_EN] & rf_rx_evt) | (led_q[`UIO_LED_SER_EN] & ser_rx_evt);
    wire tx_any = (led_q[`UIO_LED_RF_EN] & rf_tx_evt) | (led_q[`UIO_LED_SER_EN] & ser_tx_evt)
                | (led_q[`UIO_LED_HB_EN] & hb_tick);

    assign flash_evt = {tx_any, rx_any, rx_any, tx_any};

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_flash
            reg [31:0] fl_q;
            always @(posedge clock) begin
                if (!rst_n) begin
                    fl_q <= 32'h00000000;
                end else if (flash_evt[g]) begin
                    fl_q <= FLASH_CYC;
                end else if (fl_q != 32'h00000000) begin
                    fl_q <= fl_q - 32'h00000001;
                end
            end
            assign flash_on[g] = (fl_q != 32'h00000000);
        end
    endgenerate

    // ****************************************
    // link counters
    // ****************************************
    assign cnt_evt = {ack_rx_evt, rf_rx_evt, ack_tx_evt, rf_tx_evt};

    generate
        for (g = 0; g < 4; g = g + 1) begin : g_cnt
            always @(posedge clock) begin
                if (!rst_n) begin
                    cnt_q[g] <= 16'h0000;
                end else if (clr_q) begin
                    cnt_q[g] <= {15'h0000, cnt_evt[g]};
                end else if (cnt_evt[g] && cnt_q[g] != 16'hFFFF) begin
                    cnt_q[g] <= cnt_q[g] + 16'h0001;
                end
            end
        end
    endgenerate

    // ****************************************
    // pin drive
    // ****************************************
    assign pen_eff  = pull_ok(pen_q & ~dir_q);
    assign spen_eff = pull_ok(spen_q & ~sdir_q);

    always @(posedge clock) begin
        if (!rst_n) begin
            pin_out   <= `UIO_RST_OUT;
            pin_oe    <= `UIO_RST_DIR;
            pin_pu    <= 12'h000;
            pin_pd    <= 12'h000;
            pin_ana   <= `UIO_RST_ANA;
            dbg_pulse <= 1'b0;
        end else begin
            dbg_pulse <= (dbg_q != 2'h0) & (rf_tx_evt | rf_rx_evt);
            if (sleep) begin
                pin_oe  <= sdir_q;
                pin_out <= sout_q & sdir_q;
                pin_pu  <= spen_eff & {{4{spup_q[1]}}, {8{spup_q[0]}}};
                pin_pd  <= spen_eff & ~{{4{spup_q[1]}}, {8{spup_q[0]}}};
                pin_ana <= 8'h00;
            end else begin
                pin_oe  <= dir_q & ~{4'h0, ana_q} | {8'h00, led_q[3:0]};
                pin_out <= {out_q[11:4] & dir_q[11:4], (out_q[3:0] & dir_q[3:0] & ~led_q[3:0])
                         | (flash_on & led_q[3:0])};
                pin_pu  <= pen_eff & ~{4'h0, ana_q} & {{4{pup_q[1]}}, {8{pup_q[0]}}};
                pin_pd  <= pen_eff & ~{4'h0, ana_q} & ~{{4{pup_q[1]}}, {8{pup_q[0]}}};
                pin_ana <= ana_q & ~dir_q[7:0];
            end
        end
    end

endmodule

//--- verification/uio_properties.sv
module uio_props #(
    parameter HB_CYC    = 50,
    parameter RPT_CYC   = 20,
    parameter FLASH_CYC = 5
) (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [11:0] pin_out,
    input wire logic [11:0] pin_oe,
    input wire logic [11:0] pin_pu,
    input wire logic [11:0] pin_pd,
    input wire logic        rpt_send,
    input wire logic        rpt_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run_q;
    int   gap_q;

    // ****************************************
    // repeat pulse spacing tracker
    // ****************************************
    always @(posedge clock) begin
        if (!rst_n) begin
            run_q <= 1'h0;
            gap_q <= 0;
        end else begin
            run_q <= rpt_active && (run_q || rpt_send);
            gap_q <= rpt_send ? 1 : gap_q + 1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence take_s(w);
        hsel && hready && htrans[1] && hwrite == w;
    endsequence
    sequence wait_s;
        !hreadyout ##1 hreadyout;
    endsequence

    rd_wait_a: assert property (take_s(1'h0) |=> wait_s)
        else $error("read answer not after one wait state");
    wr_nowait_a: assert property (take_s(1'h1) |=> hreadyout)
        else $error("write data phase stalled");
    nopull_ab_a: assert property ((pin_pu[9:8] | pin_pd[9:8]) == 2'h0)
        else $error("pull enabled on unpulled pin");
    pull_polarity_a: assert property (!(|pin_pu[7:0] && |pin_pd[7:0]) && !(|pin_pu[11:10] && |pin_pd[11:10]))
        else $error("mixed pull polarity in one port");
    reset_idle_a: assert property ($rose(rst_n) |-> pin_oe == 12'h000 && pin_out == 12'h000 && !rpt_active)
        else $error("pins not idle after reset");
    rpt_period_a: assert property (rpt_send && run_q |-> gap_q == RPT_CYC)
        else $error("repeat send spacing wrong");
    rpt_bound_a: assert property (rpt_active && run_q |-> gap_q <= RPT_CYC)
        else $error("repeat send overdue");
    rpt_stop_a: assert property ($fell(rpt_active) |-> (!rpt_send) [*8])
        else $error("send after repeat stop");
endmodule

bind uio_top uio_props #(.HB_CYC(HB_CYC), .RPT_CYC(RPT_CYC), .FLASH_CYC(FLASH_CYC)) props_u (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu), .pin_pd(pin_pd),
    .rpt_send(rpt_send), .rpt_active(rpt_active)
);

//--- verification/uio_pads.sv
module uio_pads (
    input  wire logic [11:0] pin_out,
    input  wire logic [11:0] pin_oe,
    input  wire logic [11:0] pin_pu,
    input  wire logic [11:0] pin_pd,
    input  wire logic [11:0] ext_v,
    input  wire logic [11:0] ext_en,
    input  wire logic        clock,
    output logic      [11:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] flt_q = 12'h000;

    // floating lines wander every cycle
    always @(posedge clock) flt_q <= ~flt_q;
    always_comb
        for (int i = 0; i < 12; i++)
            level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_v[i] : pin_pu[i] ? 1'h1 : pin_pd[i] ? 1'h0 : flt_q[i];
endmodule

//--- verification/testbench.sv
`include "uio_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'h0;
    logic        rst_n = 1'h0;
    logic        hsel = 1'h0;
    logic        hwrite = 1'h0;
    logic        sleep = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [5:0]  ev = 6'h00;
    logic [11:0] ext_v = 12'h000;
    logic [11:0] ext_en = 12'h000;
    logic [31:0] rv;
    logic [11:0] d, s, o;
    wire         hreadyout, hresp, dbg_pulse, rpt_send, rpt_active;
    wire  [31:0] hrdata;
    wire  [11:0] pin_out, pin_oe, pin_pu, pin_pd, level;
    wire  [7:0]  pin_ana;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          k, m, t;
    int          cnt [4];
    int          cev [4] = '{0, 4, 1, 5};
    logic [7:0]  cofs [4] = '{`UIO_OFS_CNT_TX, `UIO_OFS_CNT_ACKS, `UIO_OFS_CNT_RX, `UIO_OFS_CNT_ACKR};
    logic [7:0]  offs [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h2C, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44};
    logic [6:0]  lw [8] = '{7'h13, 7'h13, 7'h23, 7'h23, 7'h1C, 7'h2C, 7'h1F, 7'h03};
    int          le [8] = '{1, 0, 3, 2, 1, 2, 1, 1};
    int          lp [8] = '{1, 0, 1, 0, 2, 3, 1, 9};

    uio_top #(.HB_CYC(50), .RPT_CYC(20), .FLASH_CYC(5)) dut_u (
        .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .pin_in(level), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
        .pin_pd(pin_pd), .pin_ana(pin_ana), .sleep(sleep), .rf_tx_evt(ev[0]), .rf_rx_evt(ev[1]),
        .ser_tx_evt(ev[2]), .ser_rx_evt(ev[3]), .ack_tx_evt(ev[4]), .ack_rx_evt(ev[5]),
        .dbg_pulse(dbg_pulse), .rpt_send(rpt_send), .rpt_active(rpt_active)
    );
    uio_pads pads_u (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu), .pin_pd(pin_pd), .ext_v(ext_v),
        .ext_en(ext_en), .clock(clock), .level(level));

    function automatic logic [11:0] pulls(input logic [1:0] pol, input logic up);
        logic [1:0] p;
        p = up ? pol : ~pol;
        return {{2{p[1]}}, 2'h0, {8{p[0]}}};
    endfunction
    function automatic logic [31:0] led_exp(input logic [6:0] w);
        return {25'h0, w[6:4], |w[1:0] ? 2'h0 : w[3:2], w[1:0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clock); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'h1);
        rv = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0);
        chk(rv, exp);
    endtask
    task automatic tend();
        t++;
        $display("test %0d done at %0t", t, $time);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_fail++;
            finish_test();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        t = 0;
        k = $urandom(32'h17CC);
        repeat (20) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        bus(1'h1, 8'h44, 32'hFFFF);
        bus(1'h1, 8'h84, 32'hFFFF);
        foreach (offs[i]) rd(offs[i], {30'h0, offs[i] == 8'h08, offs[i] == 8'h08});
        chk(pin_oe, 12'h000);
        chk(hresp, 1'h0);
        tend();
        for (m = 0; m < 5; m++) begin
            d = m == 0 ? 12'hFFF : m == 1 ? 12'h000 : 12'($urandom);
            s = 12'($urandom);
            o = 12'($urandom);
            ext_en <= ~d;
            ext_v <= o;
            bus(1'h1, `UIO_OFS_DIR, d);
            bus(1'h1, `UIO_OFS_DATA, s);
            repeat (3) @(posedge clock);
            chk(pin_oe, d);
            chk(pin_out & d, s & d);
            rd(`UIO_OFS_DATA, o & ~d);
        end
        tend();
        ext_en <= 12'h000;
        bus(1'h1, `UIO_OFS_DIR, 32'h0);
        bus(1'h1, `UIO_OFS_PULL_EN, 32'hFFF);
        for (m = 0; m < 4; m++) begin
            bus(1'h1, `UIO_OFS_PULL_UP, m);
            repeat (3) @(posedge clock);
            chk(pin_pu, pulls(m, 1'h1));
            chk(pin_pd, pulls(m, 1'h0));
            bus(1'h0, `UIO_OFS_DATA, 32'h0);
            chk(rv & 32'hCFF, pulls(m, 1'h1));
        end
        bus(1'h1, `UIO_OFS_ANA, 32'hFFF);
        rd(`UIO_OFS_ANA, 32'hFF);
        chk(pin_ana, 8'hFF);
        chk(pin_pu, 12'hC00);
        bus(1'h0, `UIO_OFS_DATA, 32'h0);
        chk(rv & 32'hCFF, 32'hC00);
        bus(1'h1, `UIO_OFS_ANA, 32'h0);
        tend();
        d = 12'($urandom);
        s = 12'($urandom);
        o = 12'($urandom);
        bus(1'h1, `UIO_OFS_DIR, d);
        bus(1'h1, `UIO_OFS_SDIR, s);
        bus(1'h1, `UIO_OFS_SOUT, o);
        bus(1'h1, `UIO_OFS_SPULL_EN, 32'hFFF);
        bus(1'h1, `UIO_OFS_SPULL_UP, 32'h0);
        sleep <= 1'h1;
        repeat (3) @(posedge clock);
        chk(pin_oe, s);
        chk(pin_out & s, o & s);
        chk(pin_pd, 12'hCFF & ~s);
        chk(pin_pu, 12'h000);
        sleep <= 1'h0;
        repeat (3) @(posedge clock);
        chk(pin_oe, d);
        chk(pin_pu, 12'hCFF & ~d);
        chk(pin_pd, 12'h000);
        bus(1'h1, `UIO_OFS_OUT_INIT, o);
        bus(1'h1, `UIO_OFS_CTRL, 32'h8);
        repeat (3) @(posedge clock);
        chk(pin_out & d, o & d);
        tend();
        foreach (cofs[i]) begin
            m = $urandom_range(8, 1);
            repeat (m) begin
                ev[cev[i]] <= 1'h1;
                @(posedge clock);
                ev[cev[i]] <= 1'h0;
                @(posedge clock);
            end
            rd(cofs[i], m);
        end
        bus(1'h1, `UIO_OFS_CTRL, 32'h1);
        foreach (cofs[i]) rd(cofs[i], 32'h0);
        ev[5] <= 1'h1;
        repeat (65540) @(posedge clock);
        ev[5] <= 1'h0;
        @(posedge clock);
        rd(`UIO_OFS_CNT_ACKR, 32'hFFFF);
        tend();
        bus(1'h1, `UIO_OFS_DIR, 32'h0);
        foreach (lw[i]) begin
            bus(1'h1, `UIO_OFS_LED, lw[i]);
            rd(`UIO_OFS_LED, led_exp(lw[i]));
            cnt = '{default: 0};
            ev[le[i]] <= 1'h1;
            @(posedge clock);
            ev[le[i]] <= 1'h0;
            repeat (12) begin
                @(posedge clock);
                foreach (cnt[p]) cnt[p] += pin_out[p];
            end
            foreach (cnt[p]) chk(cnt[p], p == lp[i] ? 5 : 0);
        end
        tend();
        bus(1'h1, `UIO_OFS_LED, 32'h41);
        repeat (2) begin
            k = 0;
            do begin
                o[0] = pin_out[0];
                @(posedge clock);
                k++;
            end while (!(pin_out[0] === 1'h1 && o[0] === 1'h0) && k < 200);
        end
        chk(k, 50);
        tend();
        bus(1'h1, `UIO_OFS_CTRL, 32'h2);
        k = 0;
        repeat (50) @(posedge clock) k += rpt_send;
        chk(k, 3);
        rd(`UIO_OFS_CTRL, 32'h2);
        bus(1'h1, `UIO_OFS_CTRL, 32'h4);
        repeat (2) @(posedge clock);
        k = 0;
        repeat (30) @(posedge clock) k += rpt_send;
        chk(k, 0);
        chk(rpt_active, 1'h0);
        tend();
        for (m = 0; m < 4; m++) begin
            bus(1'h1, `UIO_OFS_DEBUG, m);
            rd(`UIO_OFS_DEBUG, m);
            ev[0] <= 1'h1;
            @(posedge clock);
            ev[0] <= 1'h0;
            k = 0;
            repeat (3) @(posedge clock) k += dbg_pulse;
            chk(k, m != 0);
        end
        tend();
        finish_test();
    end
endmodule
